/* File: include/fxa_pkg.sv */
// Shared constants, types and decode functions of the fixed-point datapath
package fxa_pkg;

  // Bus and datapath widths
  localparam int DATA_W = 32;              // Fullword width
  localparam int ADDR_W = 32;              // Register bus address width
  localparam int STRB_W = DATA_W / 8;      // Byte lanes per word
  localparam int HALF_W = 16;              // Halfword operand width
  localparam int NIB_W  = 4;               // Short immediate field width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OPND1     = 32'h0000_0000;  // First operand register
  localparam logic [ADDR_W-1:0] OFS_OPND1_ODD = 32'h0000_0004;  // Odd partner of the pair
  localparam logic [ADDR_W-1:0] OFS_SRC_REG   = 32'h0000_0008;  // Second operand register
  localparam logic [ADDR_W-1:0] OFS_MEM_DATA  = 32'h0000_000c;  // Storage operand word
  localparam logic [ADDR_W-1:0] OFS_IMM       = 32'h0000_0010;  // Immediate field
  localparam logic [ADDR_W-1:0] OFS_INDEX     = 32'h0000_0014;  // Index register contents
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 32'h0000_0018;  // Opcode and start
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 32'h0000_001c;  // Condition code and state
  localparam int                WORD_LSB      = 2;              // Byte bits below a word

  // Control and status field positions
  localparam int CTRL_OP_LSB    = 0;       // Opcode byte
  localparam int CTRL_START_BIT = 8;       // Write one to execute
  localparam int CTRL_START_LANE = 1;      // Byte lane holding the start bit
  localparam int ST_DONE_BIT    = 4;       // Operation completed
  localparam int ST_BUSY_BIT    = 5;       // Operation pending
  localparam int ST_BADOP_BIT   = 6;       // Unknown opcode seen

  // Condition code flag positions
  localparam int CC_C = 3;                 // Carry or borrow
  localparam int CC_V = 2;                 // Overflow
  localparam int CC_G = 1;                 // Greater
  localparam int CC_L = 0;                 // Less

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
  localparam logic [7:0]        RST_OPCODE = 8'h00;
  localparam logic [3:0]        RST_CC     = 4'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Opcodes
  localparam logic [7:0] OPC_S_MEM   = 8'h5b;   // Subtract, storage
  localparam logic [7:0] OPC_S_REG   = 8'h0b;   // Subtract, register
  localparam logic [7:0] OPC_S_IMM   = 8'hfb;   // Subtract, long immediate
  localparam logic [7:0] OPC_S_SHORT = 8'h27;   // subtract_short_immediate
  localparam logic [7:0] OPC_SH_MEM  = 8'h4b;   // Subtract halfword, storage
  localparam logic [7:0] OPC_SH_IMM  = 8'hcb;   // subtract_half_immediate
  localparam logic [7:0] OPC_C_MEM   = 8'h59;   // Compare, storage
  localparam logic [7:0] OPC_C_REG   = 8'h09;   // Compare, register
  localparam logic [7:0] OPC_C_IMM   = 8'hf9;   // Compare, long immediate
  localparam logic [7:0] OPC_CH_MEM  = 8'h49;   // Compare halfword, storage
  localparam logic [7:0] OPC_CH_IMM  = 8'hc9;   // compare_half_immediate
  localparam logic [7:0] OPC_M_MEM   = 8'h5c;   // Multiply, storage
  localparam logic [7:0] OPC_M_REG   = 8'h1c;   // multiply_register_form

  // Operation classes
  typedef enum logic [1:0] {KIND_SUB, KIND_CMP, KIND_MUL, KIND_BAD} fxa_kind_t;

  // Second operand sources
  typedef enum logic [2:0] {
    SRC_MEM_FULL, SRC_MEM_HALF, SRC_REG, SRC_LONG_IMM, SRC_HALF_IMM, SRC_NIBBLE
  } fxa_src_t;

  // Register selection
  typedef enum logic [3:0] {
    REG_OPND1, REG_OPND1_ODD, REG_SRC_REG, REG_MEM_DATA,
    REG_IMM, REG_INDEX, REG_CTRL, REG_STATUS, REG_NONE
  } fxa_reg_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } fxa_axil_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } fxa_axil_rsp_t;

  // Whole state of the datapath block
  typedef struct packed {
    logic              aw_got;     // Write address held
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;      // Write data held
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] opnd1;      // First operand register (even of pair)
    logic [DATA_W-1:0] opnd1_odd;  // Odd register of the pair
    logic [DATA_W-1:0] src_reg;
    logic [DATA_W-1:0] mem_data;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] index;
    logic [7:0]        opcode;
    logic              pend;       // Execute at the next edge
    logic [3:0]        cc;
    logic              done;
    logic              bad_op;
  } fxa_state_t;

  // Class of an opcode
  function automatic fxa_kind_t op_kind(input logic [7:0] op);
    unique case (op)
      OPC_S_MEM, OPC_S_REG, OPC_S_IMM, OPC_S_SHORT, OPC_SH_MEM, OPC_SH_IMM: op_kind = KIND_SUB;
      OPC_C_MEM, OPC_C_REG, OPC_C_IMM, OPC_CH_MEM, OPC_CH_IMM:              op_kind = KIND_CMP;
      OPC_M_MEM, OPC_M_REG:                                                 op_kind = KIND_MUL;
      default:                                                              op_kind = KIND_BAD;
    endcase
  endfunction

  // Second operand source of an opcode
  function automatic fxa_src_t op_src(input logic [7:0] op);
    unique case (op)
      OPC_SH_MEM, OPC_CH_MEM:            op_src = SRC_MEM_HALF;
      OPC_S_REG, OPC_C_REG, OPC_M_REG:   op_src = SRC_REG;
      OPC_S_IMM, OPC_C_IMM:              op_src = SRC_LONG_IMM;
      OPC_SH_IMM, OPC_CH_IMM:            op_src = SRC_HALF_IMM;
      OPC_S_SHORT:                       op_src = SRC_NIBBLE;
      default:                           op_src = SRC_MEM_FULL;
    endcase
  endfunction

  // Register selected by a bus address
  function automatic fxa_reg_t reg_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
    unique case (word)
      OFS_OPND1:     reg_sel = REG_OPND1;
      OFS_OPND1_ODD: reg_sel = REG_OPND1_ODD;
      OFS_SRC_REG:   reg_sel = REG_SRC_REG;
      OFS_MEM_DATA:  reg_sel = REG_MEM_DATA;
      OFS_IMM:       reg_sel = REG_IMM;
      OFS_INDEX:     reg_sel = REG_INDEX;
      OFS_CTRL:      reg_sel = REG_CTRL;
      OFS_STATUS:    reg_sel = REG_STATUS;
      default:       reg_sel = REG_NONE;
    endcase
  endfunction

endpackage

/* File: src/fxa_alu.sv */
// Fixed-point subtract, compare and multiply datapath behind an AXI4-Lite slave
// Operation
// RL1 - Fullword subtract writes difference to first register
// RL2 - Subtract sets sign, overflow and borrow flags
// RL3 - Short immediate zero-extended from four bits
// RL4 - Long immediate plus index forms operand
// RL5 - Program aligns fullword storage operands
// RL6 - Halfword subtract sign-extends second operand
// RL7 - Halfword immediate sign-extended, then index added
// RL8 - Program aligns halfword storage operands
// RL9 - Compare changes only the condition code
// RL10 - Compare flags: equal, less, greater
// RL11 - Halfword compare uses sign-extended fullword
// RL12 - Multiply odd register, signed product to pair
// RL13 - High half even register, low half next
// RL14 - Program names even register for multiply
// RL15 - Overflow when signed result does not fit
// RL16 - Undefined flags carry no meaning
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fxa_alu (
  input  wire logic                  aclk,     // Processor clock
  input  wire logic                  aresetn,  // Synchronous reset, active low
  input  wire fxa_pkg::fxa_axil_req_t axi_req, // Register bus from master
  output fxa_pkg::fxa_axil_rsp_t      axi_rsp  // Register bus to master
);
  import fxa_pkg::*;

  fxa_state_t              s_reg;        // Registered state
  fxa_state_t              s_next;       // Next state
  fxa_kind_t               kind;         // Class of the held opcode
  fxa_src_t                src;          // Operand source of the held opcode
  logic [DATA_W-1:0]       opnd2;        // Formed second operand
  logic [2*DATA_W-1:0]     product;      // Multiply result
  logic [DATA_W:0]         diff_wide;    // Difference with borrow on top
  logic [DATA_W-1:0]       diff;         // Difference
  logic                    borrow;       // Unsigned borrow out
  logic                    ovf;          // Signed overflow of the difference
  logic                    cmp_lt;       // First operand signed less
  logic                    cmp_gt;       // First operand signed greater
  logic                    awready;      // Write address accepted
  logic                    wready;       // Write data accepted
  logic                    arready;      // Read address accepted
  fxa_reg_t                wsel;         // Register addressed by the held write
  fxa_reg_t                rsel;         // Register addressed by the read

  // Decode the held opcode
  assign kind = op_kind(s_reg.opcode);
  assign src  = op_src(s_reg.opcode);

  // Form the second operand
  fxa_operand #(.WIDTH(DATA_W)) u_operand (
    .src        (src),
    .mem_word   (s_reg.mem_data),
    .reg_word   (s_reg.src_reg),
    .imm_word   (s_reg.imm),
    .index_word (s_reg.index),
    .operand    (opnd2)
  );

  // Multiply the odd register by the second operand
  fxa_multiplier #(.WIDTH(DATA_W)) u_mult (
    .multiplicand (s_reg.opnd1_odd),
    .multiplier   (opnd2),
    .product      (product)
  );

  // RL1 subtract with borrow
  assign diff_wide = {1'b0, s_reg.opnd1} - {1'b0, opnd2};
  assign diff      = diff_wide[DATA_W-1:0];
  assign borrow    = diff_wide[DATA_W];
  // RL15 operand signs differ and result sign differs from the first operand
  assign ovf       = (s_reg.opnd1[DATA_W-1] != opnd2[DATA_W-1])
                     && (diff[DATA_W-1] != s_reg.opnd1[DATA_W-1]);
  // RL10 signed comparison of the operands
  assign cmp_lt    = $signed(s_reg.opnd1) < $signed(opnd2);
  assign cmp_gt    = $signed(s_reg.opnd1) > $signed(opnd2);

  // Bus handshakes: one write and one read in flight
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready  = !s_reg.w_got && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign wsel    = reg_sel(s_reg.awaddr);
  assign rsel    = reg_sel(axi_req.araddr);

  // Drive the bus outputs
  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready  = wready;
    axi_rsp.bvalid  = s_reg.bvalid;
    axi_rsp.bresp   = s_reg.bresp;
    axi_rsp.arready = arready;
    axi_rsp.rvalid  = s_reg.rvalid;
    axi_rsp.rdata   = s_reg.rdata;
    axi_rsp.rresp   = s_reg.rresp;
  end

  // Merge a write into a word under byte strobes
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Next state: bus channels, execution and register writes
  always_comb begin
    s_next = s_reg;
    // Read answer retired
    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    // Read request taken and answered from current registers
    if (arready && axi_req.arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      unique case (rsel)
        REG_OPND1:     s_next.rdata = s_reg.opnd1;
        REG_OPND1_ODD: s_next.rdata = s_reg.opnd1_odd;
        REG_SRC_REG:   s_next.rdata = s_reg.src_reg;
        REG_MEM_DATA:  s_next.rdata = s_reg.mem_data;
        REG_IMM:       s_next.rdata = s_reg.imm;
        REG_INDEX:     s_next.rdata = s_reg.index;
        REG_CTRL:      s_next.rdata = {{(DATA_W-8){1'b0}}, s_reg.opcode};
        REG_STATUS: begin
          s_next.rdata = RST_WORD;
          s_next.rdata[CC_C:CC_L]    = s_reg.cc;
          s_next.rdata[ST_DONE_BIT]  = s_reg.done;
          s_next.rdata[ST_BUSY_BIT]  = s_reg.pend;
          s_next.rdata[ST_BADOP_BIT] = s_reg.bad_op;
        end
        default: begin
          // Unmapped address reads zero with a decode error
          s_next.rdata = RST_WORD;
          s_next.rresp = RESP_DECERR;
        end
      endcase
    end
    // Write answer retired
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    // Write address and data taken in either order
    if (awready && axi_req.awvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = axi_req.awaddr;
    end
    if (wready && axi_req.wvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end
    // Execute the pending operation
    if (s_reg.pend) begin
      s_next.pend = 1'b0;
      s_next.done = 1'b1;
      unique case (kind)
        KIND_SUB: begin
          // RL1 difference replaces first operand
          s_next.opnd1 = diff;
          // RL2 flags from borrow, overflow and sign
          s_next.cc[CC_C] = borrow;
          s_next.cc[CC_V] = ovf;
          s_next.cc[CC_G] = !diff[DATA_W-1] && (diff != RST_WORD);
          s_next.cc[CC_L] = diff[DATA_W-1];
        end
        KIND_CMP: begin
          // RL10 carry and less on less, greater alone on greater
          s_next.cc[CC_C] = cmp_lt;
          // RL16 overflow left clear, meaning nothing
          s_next.cc[CC_V] = 1'b0;
          s_next.cc[CC_G] = cmp_gt;
          s_next.cc[CC_L] = cmp_lt;
        end
        KIND_MUL: begin
          // RL13 high half to even, low half to odd
          s_next.opnd1     = product[2*DATA_W-1:DATA_W];
          s_next.opnd1_odd = product[DATA_W-1:0];
        end
        default: begin
          // Unknown opcode changes nothing but the flag
          s_next.bad_op = 1'b1;
        end
      endcase
    end
    // Commit a held write and answer it
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      unique case (wsel)
        REG_OPND1:     s_next.opnd1     = merge(s_reg.opnd1, s_reg.wdata, s_reg.wstrb);
        REG_OPND1_ODD: s_next.opnd1_odd = merge(s_reg.opnd1_odd, s_reg.wdata, s_reg.wstrb);
        REG_SRC_REG:   s_next.src_reg   = merge(s_reg.src_reg, s_reg.wdata, s_reg.wstrb);
        REG_MEM_DATA:  s_next.mem_data  = merge(s_reg.mem_data, s_reg.wdata, s_reg.wstrb);
        REG_IMM:       s_next.imm       = merge(s_reg.imm, s_reg.wdata, s_reg.wstrb);
        REG_INDEX:     s_next.index     = merge(s_reg.index, s_reg.wdata, s_reg.wstrb);
        REG_CTRL: begin
          // Opcode byte, then start launches execution next edge
          if (s_reg.wstrb[0]) begin
            s_next.opcode = s_reg.wdata[CTRL_OP_LSB +: 8];
          end
          if (s_reg.wstrb[CTRL_START_LANE] && s_reg.wdata[CTRL_START_BIT]) begin
            s_next.pend   = 1'b1;
            s_next.done   = 1'b0;
            s_next.bad_op = 1'b0;
          end
        end
        REG_STATUS: begin
          // Read-only: write ignored
        end
        default: begin
          s_next.bresp = RESP_DECERR;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg           <= '0;
      s_reg.opnd1     <= RST_WORD;
      s_reg.opnd1_odd <= RST_WORD;
      s_reg.opcode    <= RST_OPCODE;
      s_reg.cc        <= RST_CC;
      s_reg.bresp     <= RESP_OKAY;
      s_reg.rresp     <= RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

  // Helper signals for the checks
  logic exec_sub;   // Subtract executes this edge
  logic exec_cmp;   // Compare executes this edge
  logic exec_mul;   // Multiply executes this edge
  logic uns_less;   // Independent unsigned less of the operands
  logic [DATA_W:0] sdiff;  // Difference of sign-extended operands
  assign exec_sub = s_reg.pend && (kind == KIND_SUB);
  assign exec_cmp = s_reg.pend && (kind == KIND_CMP);
  assign exec_mul = s_reg.pend && (kind == KIND_MUL);
  assign uns_less = s_reg.opnd1 < opnd2;
  // Overflow reference: top two bits of the wide difference disagree
  assign sdiff    = {s_reg.opnd1[DATA_W-1], s_reg.opnd1} - {opnd2[DATA_W-1], opnd2};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sub_writeback: assert property (  // RL1
    exec_sub |=> s_reg.opnd1 == $past(diff)
  ) else $error("subtract result not written back");

  chk_sub_borrow: assert property (  // RL2
    exec_sub |=> s_reg.cc[CC_C] == $past(uns_less)
      && s_reg.cc[CC_L] == s_reg.opnd1[DATA_W-1]
      && s_reg.cc[CC_G] == (!s_reg.opnd1[DATA_W-1] && s_reg.opnd1 != RST_WORD)
  ) else $error("subtract flags wrong");

  chk_nibble_zext: assert property (  // RL3
    s_reg.opcode == OPC_S_SHORT |-> opnd2 == {28'h0000000, s_reg.imm[NIB_W-1:0]}
  ) else $error("short immediate not zero-extended");

  chk_long_imm: assert property (  // RL4
    src == SRC_LONG_IMM |-> opnd2 == s_reg.imm + s_reg.index
  ) else $error("long immediate operand wrong");

  chk_half_sext: assert property (  // RL6
    src == SRC_MEM_HALF |-> opnd2[DATA_W-1:HALF_W] == {HALF_W{s_reg.mem_data[HALF_W-1]}}
      && opnd2[HALF_W-1:0] == s_reg.mem_data[HALF_W-1:0]
  ) else $error("halfword operand not sign-extended");

  chk_half_imm: assert property (  // RL7
    src == SRC_HALF_IMM |-> opnd2 - s_reg.index
      == {{HALF_W{s_reg.imm[HALF_W-1]}}, s_reg.imm[HALF_W-1:0]}
  ) else $error("halfword immediate operand wrong");

  chk_cmp_keeps: assert property (  // RL9
    exec_cmp |=> $stable(s_reg.opnd1) && $stable(s_reg.opnd1_odd)
  ) else $error("compare changed an operand");

  chk_cmp_flags: assert property (  // RL10
    exec_cmp ##1 s_reg.cc[CC_G] |-> !s_reg.cc[CC_C] && !s_reg.cc[CC_L]
  ) else $error("compare greater flags wrong");

  chk_cmp_less: assert property (  // RL10
    exec_cmp && ($signed(s_reg.opnd1) < $signed(opnd2)) |=> s_reg.cc[CC_C] && s_reg.cc[CC_L]
  ) else $error("compare less flags wrong");

  chk_mul_pair: assert property (  // RL12
    exec_mul |=> {s_reg.opnd1, s_reg.opnd1_odd} == $past(product) && $stable(s_reg.cc)
  ) else $error("multiply pair or flags wrong");

  chk_mul_low: assert property (  // RL13
    exec_mul |=>
      s_reg.opnd1_odd == $past(s_reg.opnd1_odd) * $past(opnd2)
  ) else $error("multiply low half misplaced");

  chk_sub_ovf: assert property (  // RL15
    exec_sub |=> s_reg.cc[CC_V] == $past(sdiff[DATA_W] ^ sdiff[DATA_W-1])
  ) else $error("overflow flag wrong");

  chk_exec_once: assert property (
    s_reg.pend |=> !s_reg.pend && s_reg.done
  ) else $error("execution not completed in one cycle");

  cov_sub: cover property (exec_sub ##1 s_reg.cc[CC_C]);
  cov_cmp_less: cover property (exec_cmp ##1 s_reg.cc[CC_L]);
  cov_mul: cover property (exec_mul);
  cov_ovf: cover property (exec_sub ##1 s_reg.cc[CC_V]);
  cov_bad_op: cover property (s_reg.pend && kind == KIND_BAD);

  // Zero results and equal operands leave the sign flags clear
  chk_sub_zero: assert property (  // RL2
    exec_sub && s_reg.opnd1 == opnd2 |=> !s_reg.cc[CC_G] && !s_reg.cc[CC_L]
  ) else $error("subtract zero flags wrong");

  chk_cmp_equal: assert property (  // RL10
    exec_cmp && s_reg.opnd1 == opnd2 |=> !s_reg.cc[CC_C] && !s_reg.cc[CC_G] && !s_reg.cc[CC_L]
  ) else $error("compare equal flags wrong");

  chk_bad_op_flag: assert property (
    s_reg.pend && kind == KIND_BAD |=>
      s_reg.bad_op && $stable(s_reg.opnd1) && $stable(s_reg.cc)
  ) else $error("unknown opcode changed state");

  // Bus channel checks
  chk_write_single: assert property (
    s_reg.bvalid |-> !awready && !wready
  ) else $error("write accepted while answer stands");

  chk_read_holds: assert property (
    s_reg.rvalid && !axi_req.rready |=> s_reg.rvalid && $stable(s_reg.rdata)
  ) else $error("read answer dropped early");
endmodule

/* File: src/fxa_multiplier.sv */
// Signed fullword multiplier giving a double-width product
`timescale 1ns/1ps
module fxa_multiplier #(
  parameter int WIDTH = fxa_pkg::DATA_W
) (
  input  wire logic [WIDTH-1:0]   multiplicand,  // Odd register of the pair
  input  wire logic [WIDTH-1:0]   multiplier,    // Second operand
  output logic      [2*WIDTH-1:0] product        // Signed product, high half first
);
  import fxa_pkg::*;

  // Refuse a width too narrow for a sign
  if (WIDTH < 2) begin : g_bad_width
    $error("fxa_multiplier: WIDTH must be at least two");
  end

  logic signed [2*WIDTH-1:0] ext_a;  // Sign-extended multiplicand
  logic signed [2*WIDTH-1:0] ext_b;  // Sign-extended multiplier

  // RL12 signed operands at full width
  assign ext_a   = {{WIDTH{multiplicand[WIDTH-1]}}, multiplicand};
  assign ext_b   = {{WIDTH{multiplier[WIDTH-1]}}, multiplier};
  assign product = ext_a * ext_b;
endmodule

/* File: src/fxa_operand.sv */
// Second operand former for all operand formats
`timescale 1ns/1ps
module fxa_operand #(
  parameter int WIDTH = fxa_pkg::DATA_W
) (
  input  wire fxa_pkg::fxa_src_t src,         // Operand source
  input  wire logic [WIDTH-1:0]  mem_word,    // Storage operand
  input  wire logic [WIDTH-1:0]  reg_word,    // Second operand register
  input  wire logic [WIDTH-1:0]  imm_word,    // Immediate field
  input  wire logic [WIDTH-1:0]  index_word,  // Index register contents
  output logic      [WIDTH-1:0]  operand      // Formed fullword operand
);
  import fxa_pkg::*;

  // Refuse widths the extensions cannot serve
  if (WIDTH <= HALF_W) begin : g_bad_width
    $error("fxa_operand: WIDTH must exceed the halfword width");
  end

  logic [WIDTH-1:0] mem_half_ext;  // Sign-extended storage halfword
  logic [WIDTH-1:0] imm_half_ext;  // Sign-extended immediate halfword

  // RL6 sign extend halfword
  assign mem_half_ext = {{(WIDTH-HALF_W){mem_word[HALF_W-1]}}, mem_word[HALF_W-1:0]};
  assign imm_half_ext = {{(WIDTH-HALF_W){imm_word[HALF_W-1]}}, imm_word[HALF_W-1:0]};

  // Select and form the operand
  always_comb begin
    unique case (src)
      // RL11 halfword sign extension
      SRC_MEM_HALF: operand = mem_half_ext;
      SRC_REG:      operand = reg_word;
      // RL4 immediate plus index
      SRC_LONG_IMM: operand = imm_word + index_word;
      // RL7 extended immediate plus index
      SRC_HALF_IMM: operand = imm_half_ext + index_word;
      // RL3 zero extend nibble
      SRC_NIBBLE:   operand = {{(WIDTH-NIB_W){1'b0}}, imm_word[NIB_W-1:0]};
      default:      operand = mem_word;
    endcase
  end
endmodule

/* File: verification/fxa_alu_test.sv */
// Self-checking bench of the fixed-point datapath
`timescale 1ns/1ps
module fxa_alu_test;
  import fxa_pkg::*;
  // One operation: opcode, operands, expected pair and flags
  typedef struct packed {
    logic [7:0]  op;
    logic [31:0] a, b, hi, lo;
    logic [3:0]  cc;
  } fxa_row_t;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  fxa_axil_req_t req;
  fxa_axil_rsp_t rsp;
  int            err_total = 0;
  int            comparisons = 0;
  logic [31:0]   rd;
  logic [1:0]    rs;
  fxa_row_t      rows [13];
  always #5 aclk = ~aclk;
  fxa_alu dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp));
  fxa_master mst (.aclk(aclk), .rsp(rsp), .req(req));
  // Compare one word and count it
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d);
    mst.wr(a, d, rs);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  task automatic rchk(input string n, input logic [31:0] a, e);
    mst.rd(a, rd, rs);
    chk(n, e, rd);
    chk("rresp_okay", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end
  initial begin
    rows = '{'{8'h5b, 32'h44444444, 32'h44444444, 32'h0, 32'h44444444, 4'h0},
      '{8'h0b, 32'h80000000, 32'h00000001, 32'h7fffffff, 32'h80000000, 4'h6},
      '{8'hfb, 32'h00000010, 32'h00000004, 32'h0000000a, 32'h00000010, 4'h2},
      '{8'h27, 32'h00000003, 32'hfffffff5, 32'hfffffffe, 32'h00000003, 4'h9},
      '{8'h4b, 32'h00123456, 32'h1234fff4, 32'h00123462, 32'h00123456, 4'ha},
      '{8'hcb, 32'h00000000, 32'h0000fff0, 32'h0000000e, 32'h00000000, 4'ha},
      '{8'h59, 32'h04321243, 32'h04321243, 32'h04321243, 32'h04321243, 4'h0},
      '{8'h09, 32'h00000004, 32'h00000005, 32'h00000004, 32'h00000004, 4'h9},
      '{8'hf9, 32'hfffffffe, 32'h00000001, 32'hfffffffe, 32'hfffffffe, 4'h9},
      '{8'h49, 32'hf4567891, 32'h00003123, 32'hf4567891, 32'hf4567891, 4'h9},
      '{8'hc9, 32'hffffffff, 32'h00008000, 32'hffffffff, 32'hffffffff, 4'h2},
      '{8'h5c, 32'h00002431, 32'h43120000, 32'h0000097b, 32'h5e720000, 4'h2},
      '{8'h1c, 32'h12345678, 32'h00010000, 32'h00001234, 32'h56780000, 4'h2}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("reset_status", OFS_STATUS, 32'h0);
    rchk("reset_opnd1", OFS_OPND1, 32'h0);
    wr(OFS_INDEX, 32'h2);
    // Every opcode once; compares ignore the overflow flag
    foreach (rows[i]) begin
      wr(OFS_OPND1, rows[i].a);
      wr(OFS_OPND1_ODD, rows[i].a);
      wr(OFS_SRC_REG, rows[i].b);
      wr(OFS_MEM_DATA, rows[i].b);
      wr(OFS_IMM, rows[i].b);
      wr(OFS_CTRL, {23'h0, 1'b1, rows[i].op});
      rchk("opnd1", OFS_OPND1, rows[i].hi);
      rchk("opnd1_odd", OFS_OPND1_ODD, rows[i].lo);
      mst.rd(OFS_STATUS, rd, rs);
      chk("status", {28'h1, rows[i].cc}, rd & (rows[i].op[3:0] == 4'h9 ? 32'h7b : 32'h7f));
    end
    // Unmapped place, read-only status, unknown opcode
    mst.rd(32'h20, rd, rs);
    chk("rresp", {30'h0, RESP_DECERR}, {30'h0, rs});
    mst.wr(32'h20, 32'h5, rs);
    chk("bresp_unmapped", {30'h0, RESP_DECERR}, {30'h0, rs});
    wr(OFS_STATUS, 32'h0);
    rchk("status_ro", OFS_STATUS, 32'h12);
    wr(OFS_CTRL, 32'h1ff);
    rchk("status_bad", OFS_STATUS, 32'h52);
    rchk("opnd1_kept", OFS_OPND1, 32'h00001234);
    // Reset in mid-run clears results and flags
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("rerun_status", OFS_STATUS, 32'h0);
    rchk("rerun_opnd1", OFS_OPND1, 32'h0);
    complete_run();
  end
endmodule

/* File: verification/fxa_master.sv */
// Register bus master standing for the decode, register file and memory path
`timescale 1ns/1ps
module fxa_master
  import fxa_pkg::*;
(
  input  wire logic                   aclk,  // Processor clock
  input  wire fxa_pkg::fxa_axil_rsp_t rsp,   // Answers from the datapath
  output fxa_pkg::fxa_axil_req_t      req    // Requests to the datapath
);
  initial req = '0;
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // Each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  // Read one word and hold rready until the answer
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule
